// ===== rtl/switch_port_regs.svh
// Register offsets, field positions, reset values and fixed codes of the port capability bank
`ifndef SWITCH_PORT_REGS_SVH
`define SWITCH_PORT_REGS_SVH

// ============================================================
// Register offsets (byte addresses in configuration space)
`define PIN_CTRL_OFFSET 8'h74
`define CAP_HDR_OFFSET 8'hc0
`define DEV_CAP_OFFSET 8'hc4

// ============================================================
// Capability header fields
`define CAP_ID_LSB 0
`define CAP_ID_VALUE 8'h10
`define NEXT_PTR_LSB 8
`define NEXT_PTR_VALUE 8'h00
`define CAP_VER_LSB 16
`define CAP_VER_VALUE 4'h2
`define PORT_TYPE_LSB 20
`define PORT_TYPE_UP 4'h5
`define PORT_TYPE_DOWN 4'h6
`define SLOT_BIT 24
`define MSG_NUM_LSB 25
`define MSG_NUM_VALUE 5'h00

// ============================================================
// Device capabilities fields
`define MPS_LSB 0
`define PHANTOM_LSB 3
`define PHANTOM_VALUE 2'h0
`define EXT_TAG_BIT 5
`define L0S_LAT_LSB 6
`define L1_LAT_LSB 9
`define LAT_VALUE 3'h0
`define RBER_BIT 15
`define RBER_RESET 1'b1
`define SPL_VAL_LSB 18
`define SPL_VAL_RESET 8'h00
`define SPL_SCALE_LSB 26
`define SPL_SCALE_RESET 2'h0

// ============================================================
// Pin control fields (upper pins, one nibble each)
`define PIN_FIRST_BIT 24
`define PIN_STRIDE 4
`define PIN_COUNT 2
`define PIN_IN_RESET 1'b1
`define PIN_DIR_RESET 1'b0
`define PIN_OUT_RESET 1'b0

`endif

// ===== rtl/switch_port_pkg.sv
// Types shared by the port capability bank
package switch_port_pkg;

  // Maximum payload size codes
  typedef enum logic [2:0] {
    PAYLOAD_128 = 3'h0,
    PAYLOAD_256 = 3'h1,
    PAYLOAD_512 = 3'h2
  } payload_code_t;

  // Configuration address (byte address)
  typedef logic [7:0] cfg_addr_t;

endpackage : switch_port_pkg

// ===== rtl/gpio_pin_slice.sv
// One general-purpose pin: sampled input, direction and output value bits
`timescale 1ns/1ps
`default_nettype none
`include "switch_port_regs.svh"

module gpio_pin_slice (
  input wire logic sys_clk_in,      // Core clock
  input wire logic reset_in,        // Synchronous reset, active high
  input wire logic pin_in,          // Level seen on the pin
  input wire logic wr_en_in,        // Write strobe for this nibble
  input wire logic dir_wdata_in,    // New direction value
  input wire logic out_wdata_in,    // New output value
  output logic pin_out,             // Value driven onto the pin
  output logic pin_oe_n_out,        // Low while the pin is driven
  output logic in_state_out,        // Sampled pin level
  output logic dir_state_out,       // Direction bit
  output logic out_state_out        // Output value bit
);

  logic in_reg, in_next;    // Sampled input
  logic dir_reg, dir_next;  // 1 = output
  logic out_reg, out_next;  // Output value

  // Next values for the pin bits
  always_comb begin
    if (reset_in) begin
      in_next = `PIN_IN_RESET;
      dir_next = `PIN_DIR_RESET;
      out_next = `PIN_OUT_RESET;
    end else begin
      in_next = pin_in;
      dir_next = wr_en_in ? dir_wdata_in : dir_reg;
      out_next = wr_en_in ? out_wdata_in : out_reg;
    end
  end

  // Register the pin bits
  always_ff @(posedge sys_clk_in) begin
    in_reg <= in_next;
    dir_reg <= dir_next;
    out_reg <= out_next;
  end

  // Drive only while the direction selects output
  assign pin_out = out_reg;
  assign pin_oe_n_out = ~dir_reg;
  assign in_state_out = in_reg;
  assign dir_state_out = dir_reg;
  assign out_state_out = out_reg;

endmodule : gpio_pin_slice
`default_nettype wire

// ===== rtl/switch_port_pcie_capability_regs.sv
// Port capability header, device capabilities and upper pin control registers
`timescale 1ns/1ps
`default_nettype none
`include "switch_port_regs.svh"

// Overview of operation
// - Pin input bits read sampled pin, reset one
// - Direction bits writable, one means output, reset zero
// - Output value driven only when direction is output
// - Capability identifier reads fixed code
// - Next capability pointer always reads zero
// - Capability version always reads two
// - Port type 0101b upstream, 0110b downstream
// - Slot present per port, sideband load overrides
// - Interrupt message number always reads zero
// - Payload codes 128/256/512, sideband overridable
// - Payload strap selects 001b or 010b reset
// - Phantom function support always reads zero
// - Extended tag support always reads zero
// - Both latency fields read-only, reset zero
// - Role-based error bit resets one, overridable
// - Upstream slot power value from message
// - Upstream slot power scale from message
module switch_port_pcie_capability_regs (
  input wire logic sys_clk_in,                          // Core clock, 100 MHz
  input wire logic reset_in,                            // Synchronous reset, active high
  input wire logic upstream_port_in,                    // Strap: 1 = upstream port
  input wire logic payload_size_strap_in,               // Strap: 1 = 512-byte payload
  input wire switch_port_pkg::cfg_addr_t cfg_addr_in,   // Configuration byte address
  input wire logic cfg_rd_in,                           // Configuration read strobe
  input wire logic cfg_wr_in,                           // Configuration write strobe
  input wire logic [31:0] cfg_wdata_in,                 // Write data
  input wire logic [3:0] cfg_be_in,                     // Byte enables
  output logic [31:0] cfg_rdata_out,                    // Read data
  output logic cfg_rvalid_out,                          // Read data valid pulse
  input wire logic sb_load_in,                          // Sideband management load strobe
  input wire logic sb_slot_present_in,                  // Loaded slot-present value
  input wire switch_port_pkg::payload_code_t sb_payload_in, // Loaded payload code
  input wire logic sb_role_err_in,                      // Loaded role-based error value
  input wire logic spl_msg_in,                          // Slot power limit message received
  input wire logic [7:0] spl_value_in,                  // Message power value
  input wire logic [1:0] spl_scale_in,                  // Message power scale
  input wire logic [1:0] gpio_in,                       // Pin levels
  output logic [1:0] gpio_out,                          // Pin drive values
  output logic [1:0] gpio_oe_n_out                      // Pin enables, low drives
);
  import switch_port_pkg::*;

  // ============================================================
  // Captured straps and loadable defaults
  logic upstream_reg, upstream_next;           // Port role
  logic slot_reg, slot_next;                   // Slot present
  payload_code_t mps_reg, mps_next;            // Max payload supported
  logic rber_reg, rber_next;                   // Role-based error reporting
  logic [7:0] spl_val_reg, spl_val_next;       // Captured power value
  logic [1:0] spl_scale_reg, spl_scale_next;   // Captured power scale
  logic sb_payload_ok;                         // Loaded code is not reserved

  // Only the three defined payload codes may be loaded
  always_comb begin
    unique case (sb_payload_in)
      PAYLOAD_128, PAYLOAD_256, PAYLOAD_512: sb_payload_ok = 1'b1;
      default: sb_payload_ok = 1'b0;  // Reserved code
    endcase
  end

  // Next values of the capability state
  always_comb begin
    upstream_next = upstream_reg;
    slot_next = slot_reg;
    mps_next = mps_reg;
    rber_next = rber_reg;
    spl_val_next = spl_val_reg;
    spl_scale_next = spl_scale_reg;
    if (reset_in) begin
      // Straps are caught while reset is held
      upstream_next = upstream_port_in;
      slot_next = ~upstream_port_in;
      mps_next = payload_size_strap_in ? PAYLOAD_512 : PAYLOAD_256;
      rber_next = `RBER_RESET;
      spl_val_next = `SPL_VAL_RESET;
      spl_scale_next = `SPL_SCALE_RESET;
    end else begin
      // Sideband management load replaces defaults
      if (sb_load_in) begin
        slot_next = sb_slot_present_in;
        rber_next = sb_role_err_in;
        if (sb_payload_ok) begin
          mps_next = sb_payload_in;
        end
      end
      // Slot power message captured on the upstream port only
      if (spl_msg_in && upstream_reg) begin
        spl_val_next = spl_value_in;
        spl_scale_next = spl_scale_in;
      end
    end
  end

  // Register the capability state
  always_ff @(posedge sys_clk_in) begin
    upstream_reg <= upstream_next;
    slot_reg <= slot_next;
    mps_reg <= mps_next;
    rber_reg <= rber_next;
    spl_val_reg <= spl_val_next;
    spl_scale_reg <= spl_scale_next;
  end

  // ============================================================
  // Pin control slices
  logic pin_wr;                      // Write to the pin nibbles
  logic [1:0] pin_in_state;          // Sampled levels
  logic [1:0] pin_dir_state;         // Direction bits
  logic [1:0] pin_out_state;         // Output value bits

  // Only the top byte holds the pin nibbles
  assign pin_wr = cfg_wr_in && ({cfg_addr_in[7:2], 2'b00} == `PIN_CTRL_OFFSET) && cfg_be_in[3];

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pin
      gpio_pin_slice u_slice (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .pin_in(gpio_in[gi]),
        .wr_en_in(pin_wr),
        .dir_wdata_in(cfg_wdata_in[`PIN_FIRST_BIT + `PIN_STRIDE * gi + 1]),
        .out_wdata_in(cfg_wdata_in[`PIN_FIRST_BIT + `PIN_STRIDE * gi + 2]),
        .pin_out(gpio_out[gi]),
        .pin_oe_n_out(gpio_oe_n_out[gi]),
        .in_state_out(pin_in_state[gi]),
        .dir_state_out(pin_dir_state[gi]),
        .out_state_out(pin_out_state[gi])
      );
    end
  endgenerate

  // ============================================================
  // Register images
  logic [31:0] cap_hdr_word;   // Capability header
  logic [31:0] dev_cap_word;   // Device capabilities
  logic [31:0] pin_word;       // Upper pin control

  // Assemble the words; every unnamed bit stays zero
  always_comb begin
    cap_hdr_word = 32'h0000_0000;
    cap_hdr_word[`CAP_ID_LSB +: 8] = `CAP_ID_VALUE;
    cap_hdr_word[`NEXT_PTR_LSB +: 8] = `NEXT_PTR_VALUE;
    cap_hdr_word[`CAP_VER_LSB +: 4] = `CAP_VER_VALUE;
    cap_hdr_word[`PORT_TYPE_LSB +: 4] = upstream_reg ? `PORT_TYPE_UP : `PORT_TYPE_DOWN;
    cap_hdr_word[`SLOT_BIT] = slot_reg;
    cap_hdr_word[`MSG_NUM_LSB +: 5] = `MSG_NUM_VALUE;
    dev_cap_word = 32'h0000_0000;
    dev_cap_word[`MPS_LSB +: 3] = mps_reg;
    dev_cap_word[`PHANTOM_LSB +: 2] = `PHANTOM_VALUE;
    dev_cap_word[`EXT_TAG_BIT] = 1'b0;
    dev_cap_word[`L0S_LAT_LSB +: 3] = `LAT_VALUE;
    dev_cap_word[`L1_LAT_LSB +: 3] = `LAT_VALUE;
    dev_cap_word[`RBER_BIT] = rber_reg;
    dev_cap_word[`SPL_VAL_LSB +: 8] = spl_val_reg;
    dev_cap_word[`SPL_SCALE_LSB +: 2] = spl_scale_reg;
    pin_word = 32'h0000_0000;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      pin_word[`PIN_FIRST_BIT + `PIN_STRIDE * i] = pin_in_state[i];
      pin_word[`PIN_FIRST_BIT + `PIN_STRIDE * i + 1] = pin_dir_state[i];
      pin_word[`PIN_FIRST_BIT + `PIN_STRIDE * i + 2] = pin_out_state[i];
    end
  end

  // ============================================================
  // Read port
  logic [31:0] rdata_reg, rdata_next;  // Read data
  logic rvalid_reg, rvalid_next;       // Read answer

  // Decode the read; unmapped words answer zero
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (reset_in) begin
      rdata_next = 32'h0000_0000;
    end else if (cfg_rd_in) begin
      rvalid_next = 1'b1;
      if ({cfg_addr_in[7:2], 2'b00} == `CAP_HDR_OFFSET) begin
        rdata_next = cap_hdr_word;
      end else if ({cfg_addr_in[7:2], 2'b00} == `DEV_CAP_OFFSET) begin
        rdata_next = dev_cap_word;
      end else if ({cfg_addr_in[7:2], 2'b00} == `PIN_CTRL_OFFSET) begin
        rdata_next = pin_word;
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
  end

  // Register the read answer
  always_ff @(posedge sys_clk_in) begin
    rdata_reg <= rdata_next;
    rvalid_reg <= rvalid_next;
  end

  assign cfg_rdata_out = rdata_reg;
  assign cfg_rvalid_out = rvalid_reg;

  // ============================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_hdr_read;
    cfg_rd_in && ({cfg_addr_in[7:2], 2'b00} == `CAP_HDR_OFFSET);
  endsequence

  sequence s_cap_read;
    cfg_rd_in && ({cfg_addr_in[7:2], 2'b00} == `DEV_CAP_OFFSET);
  endsequence

  sequence s_pin_read;
    cfg_rd_in && ({cfg_addr_in[7:2], 2'b00} == `PIN_CTRL_OFFSET);
  endsequence

  // The first edge out of reset still holds the reset level, so it is left out here
  a_pin_input_follow: assert property (!$past(reset_in) ##0 s_pin_read ##1 1'b1 |->
    cfg_rdata_out[24] == $past(gpio_in[0], 2) && cfg_rdata_out[28] == $past(gpio_in[1], 2))
    else $error("pin input bit does not track pin");

  a_pin_dir_write: assert property (pin_wr ##1 s_pin_read |=>
    cfg_rdata_out[25] == $past(cfg_wdata_in[25], 2) && cfg_rdata_out[29] == $past(cfg_wdata_in[29], 2))
    else $error("direction bit did not take write");

  a_pin_drive_gate: assert property (pin_wr |=>
    gpio_oe_n_out == ~{$past(cfg_wdata_in[29]), $past(cfg_wdata_in[25])}
    && gpio_out == {$past(cfg_wdata_in[30]), $past(cfg_wdata_in[26])})
    else $error("pin drive does not follow direction and value");

  a_hdr_fixed_fields: assert property (s_hdr_read |=>
    cfg_rvalid_out && cfg_rdata_out[19:0] == 20'h2_0010 && cfg_rdata_out[31:25] == 7'h00)
    else $error("capability header fixed fields wrong");

  a_port_type_code: assert property (s_hdr_read |=>
    cfg_rdata_out[23:20] == (upstream_reg ? 4'h5 : 4'h6))
    else $error("port type code wrong");

  a_slot_sb_load: assert property (sb_load_in ##1 s_hdr_read |=>
    cfg_rdata_out[24] == $past(sb_slot_present_in, 2))
    else $error("slot present not loaded");

  a_cap_fixed_zero: assert property (s_cap_read |=>
    cfg_rdata_out[14:3] == 12'h000 && cfg_rdata_out[17:16] == 2'h0 && cfg_rdata_out[31:28] == 4'h0)
    else $error("device capability fixed bits not zero");

  a_payload_legal: assert property (s_cap_read |=>
    cfg_rdata_out[2:0] inside {3'h0, 3'h1, 3'h2})
    else $error("payload code reserved");

  a_spl_capture: assert property (spl_msg_in && upstream_reg && !sb_load_in |=>
    spl_val_reg == $past(spl_value_in) && spl_scale_reg == $past(spl_scale_in))
    else $error("slot power limit not captured");

  a_spl_downstream: assert property (!upstream_reg |=> $stable(spl_val_reg) && $stable(spl_scale_reg))
    else $error("downstream port changed slot power");

  a_pin_reserved: assert property (s_pin_read |=> cfg_rdata_out[23:0] == 24'h0 && !cfg_rdata_out[27] && !cfg_rdata_out[31])
    else $error("reserved pin bits not zero");

  // A read at the first edge out of reset shows the reset level of the pins
  a_pin_input_reset: assert property ($past(reset_in) ##0 s_pin_read |=>
    cfg_rdata_out[24] && cfg_rdata_out[28])
    else $error("pin input bit not one after reset");

  // Payload code caught from the strap while reset is held
  a_payload_strap: assert property ($fell(reset_in) |->
    mps_reg == ($past(payload_size_strap_in) ? PAYLOAD_512 : PAYLOAD_256))
    else $error("payload code does not follow strap");

  // Loadable defaults and captured power fields leave reset at their reset values
  a_reset_defaults: assert property ($fell(reset_in) |->
    rber_reg == `RBER_RESET && slot_reg == !$past(upstream_port_in)
    && spl_val_reg == `SPL_VAL_RESET && spl_scale_reg == `SPL_SCALE_RESET)
    else $error("loadable defaults wrong after reset");

  // A defined payload code is taken by the sideband load
  a_payload_taken: assert property (sb_load_in && (sb_payload_in inside {PAYLOAD_128, PAYLOAD_256, PAYLOAD_512}) |=>
    mps_reg == $past(sb_payload_in))
    else $error("payload code not loaded");

  // A reserved payload code leaves the field as it was
  a_payload_refused: assert property (sb_load_in && !(sb_payload_in inside {PAYLOAD_128, PAYLOAD_256, PAYLOAD_512}) |=>
    $stable(mps_reg))
    else $error("reserved payload code loaded");

  // Role-based error bit follows the sideband load
  a_rber_load: assert property (sb_load_in |=>
    rber_reg == $past(sb_role_err_in))
    else $error("role-based error bit not loaded");

  // Direction and value bits move only on a pin write
  a_pin_hold_idle: assert property (!pin_wr |=>
    $stable(pin_dir_state) && $stable(pin_out_state))
    else $error("pin bits changed without a write");

  // Pin drive and enable move only on a pin write
  a_pin_drive_hold: assert property (!pin_wr |=>
    $stable(gpio_oe_n_out) && $stable(gpio_out))
    else $error("pin drive changed without a write");

  // Reads of words outside the bank still answer, with zero
  a_unmapped_zero: assert property (cfg_rd_in
    && !({cfg_addr_in[7:2], 2'b00} inside {`CAP_HDR_OFFSET, `DEV_CAP_OFFSET, `PIN_CTRL_OFFSET})
    |=> cfg_rvalid_out && cfg_rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule : switch_port_pcie_capability_regs
`default_nettype wire

// ===== tb/tb_switch_port_pcie_capability_regs.sv
// Self-checking bench for the port capability and pin control register bank
`timescale 1ns/1ps
`default_nettype none

module tb_switch_port_pcie_capability_regs;
  import switch_port_pkg::*;

  // ============================================================
  // Stimulus and observation signals
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic upstream_port_in = 1'b0;
  logic payload_size_strap_in = 1'b0;
  cfg_addr_t cfg_addr_in = 8'h00;
  logic cfg_rd_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic [31:0] cfg_wdata_in = 32'h0;
  logic [3:0] cfg_be_in = 4'h0;
  logic [31:0] cfg_rdata_out;
  logic cfg_rvalid_out;
  logic sb_load_in = 1'b0;
  logic sb_slot_present_in = 1'b0;
  payload_code_t sb_payload_in = PAYLOAD_128;
  logic sb_role_err_in = 1'b0;
  logic spl_msg_in = 1'b0;
  logic [7:0] spl_value_in = 8'h00;
  logic [1:0] spl_scale_in = 2'h0;
  logic [1:0] gpio_in = 2'h0;
  logic [1:0] gpio_out;
  logic [1:0] gpio_oe_n_out;
  int fails = 0;        // Mismatches seen
  int n_compared = 0;   // Comparisons made
  int cycles = 0;       // Hang guard

  // Device under test
  switch_port_pcie_capability_regs switch_port_pcie_capability_regs_inst (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .upstream_port_in(upstream_port_in),
    .payload_size_strap_in(payload_size_strap_in), .cfg_addr_in(cfg_addr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_be_in(cfg_be_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out), .sb_load_in(sb_load_in),
    .sb_slot_present_in(sb_slot_present_in), .sb_payload_in(sb_payload_in), .sb_role_err_in(sb_role_err_in),
    .spl_msg_in(spl_msg_in), .spl_value_in(spl_value_in), .spl_scale_in(spl_scale_in),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n_out(gpio_oe_n_out)
  );

  // ============================================================
  // Clock and hang guard
  always #5 sys_clk_in = ~sys_clk_in;

  // Ends the run if the sequence stalls
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      $display("ERROR t=%0t run did not finish in time", $time);
      fails++;
      print_verdict();
    end
  end

  // ============================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : chk

  // Reset with the given straps held for 8 cycles
  task automatic do_reset(input logic up, input logic strap);
    @(posedge sys_clk_in);
    upstream_port_in <= up;
    payload_size_strap_in <= strap;
    reset_in <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
    reset_in <= 1'b0;
  endtask : do_reset

  // One read; data and a single-cycle valid pulse are checked
  task automatic rd_chk(input cfg_addr_t a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    cfg_addr_in <= a;
    cfg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    chk({31'h0, cfg_rvalid_out}, 32'h1);
    chk(cfg_rdata_out, exp);
    @(posedge sys_clk_in);
    #1;
    chk({31'h0, cfg_rvalid_out}, 32'h0);
  endtask : rd_chk

  // One write pulse; takes effect at the edge that samples it
  task automatic wr(input cfg_addr_t a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk_in);
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    cfg_be_in <= be;
    cfg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_wr_in <= 1'b0;
    #1;
  endtask : wr

  // Sideband load pulse
  task automatic sb_load(input logic slot, input payload_code_t pl, input logic rber);
    @(posedge sys_clk_in);
    sb_slot_present_in <= slot;
    sb_payload_in <= pl;
    sb_role_err_in <= rber;
    sb_load_in <= 1'b1;
    @(posedge sys_clk_in);
    sb_load_in <= 1'b0;
  endtask : sb_load

  // Slot power limit message pulse
  task automatic spl_msg(input logic [7:0] v, input logic [1:0] s);
    @(posedge sys_clk_in);
    spl_value_in <= v;
    spl_scale_in <= s;
    spl_msg_in <= 1'b1;
    @(posedge sys_clk_in);
    spl_msg_in <= 1'b0;
  endtask : spl_msg

  // ============================================================
  // Scenarios
  // Downstream port, 256-byte strap: every field at its reset value
  task automatic test_reset_values();
    do_reset(1'b0, 1'b0);
    // First read at the first edge out of reset, pins held low
    cfg_addr_in <= 8'h74;
    cfg_rd_in <= 1'b1;
    #1;
    chk({30'h0, gpio_oe_n_out}, 32'h3);
    chk({30'h0, gpio_out}, 32'h0);
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    chk({31'h0, cfg_rvalid_out}, 32'h1);
    chk(cfg_rdata_out, 32'h11000000);
    rd_chk(8'h74, 32'h00000000);
    rd_chk(8'hc0, {2'h0, 5'h00, 1'b1, 4'h6, 4'h2, 8'h00, 8'h10});
    rd_chk(8'hc4, {4'h0, 2'h0, 8'h00, 2'h0, 1'b1, 3'h0, 3'h0, 3'h0, 1'b0, 2'h0, 3'h1});
    $display("test_reset_values done");
  endtask : test_reset_values

  // Direction and output bits, pin levels, byte enable and reserved bits
  task automatic test_pin_writes();
    @(posedge sys_clk_in);
    gpio_in <= 2'b01;
    wr(8'h74, 32'hffffffff, 4'h8);
    chk({30'h0, gpio_oe_n_out}, 32'h0);
    chk({30'h0, gpio_out}, 32'h3);
    rd_chk(8'h74, 32'h67000000);
    wr(8'h74, 32'h00000000, 4'h7);
    rd_chk(8'h74, 32'h67000000);
    @(posedge sys_clk_in);
    gpio_in <= 2'b10;
    wr(8'h74, 32'h42000000, 4'h8);
    chk({30'h0, gpio_oe_n_out}, 32'h2);
    chk({31'h0, gpio_out[0]}, 32'h0);
    rd_chk(8'h74, 32'h52000000);
    $display("test_pin_writes done");
  endtask : test_pin_writes

  // Writes to read-only words, unmapped read, message on a downstream port
  task automatic test_read_only();
    wr(8'hc0, 32'hffffffff, 4'hf);
    wr(8'hc4, 32'hffffffff, 4'hf);
    spl_msg(8'ha5, 2'h3);
    rd_chk(8'hc0, 32'h01620010);
    rd_chk(8'hc4, 32'h00008001);
    rd_chk(8'h80, 32'h00000000);
    $display("test_read_only done");
  endtask : test_read_only

  // Sideband loads, every payload code, reserved code refused
  task automatic test_sideband();
    sb_load(1'b0, PAYLOAD_128, 1'b0);
    rd_chk(8'hc0, 32'h00620010);
    rd_chk(8'hc4, 32'h00000000);
    sb_load(1'b1, payload_code_t'(3'h7), 1'b1);
    rd_chk(8'hc0, 32'h01620010);
    rd_chk(8'hc4, 32'h00008000);
    sb_load(1'b1, PAYLOAD_512, 1'b1);
    rd_chk(8'hc4, 32'h00008002);
    sb_load(1'b1, PAYLOAD_256, 1'b1);
    rd_chk(8'hc4, 32'h00008001);
    $display("test_sideband done");
  endtask : test_sideband

  // Back to back: pin write, pin read with sideband load, header read
  task automatic test_back_to_back();
    @(posedge sys_clk_in);
    cfg_addr_in <= 8'h74;
    cfg_wdata_in <= 32'h22000000;
    cfg_be_in <= 4'h8;
    cfg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_wr_in <= 1'b0;
    cfg_rd_in <= 1'b1;
    sb_slot_present_in <= 1'b0;
    sb_payload_in <= PAYLOAD_256;
    sb_role_err_in <= 1'b1;
    sb_load_in <= 1'b1;
    #1;
    chk({30'h0, gpio_oe_n_out}, 32'h0);
    chk({30'h0, gpio_out}, 32'h0);
    @(posedge sys_clk_in);
    cfg_addr_in <= 8'hc0;
    sb_load_in <= 1'b0;
    #1;
    chk({31'h0, cfg_rvalid_out}, 32'h1);
    chk(cfg_rdata_out, 32'h32000000);
    @(posedge sys_clk_in);
    cfg_rd_in <= 1'b0;
    #1;
    chk({31'h0, cfg_rvalid_out}, 32'h1);
    chk(cfg_rdata_out, 32'h00620010);
    rd_chk(8'hc4, 32'h00008001);
    $display("test_back_to_back done");
  endtask : test_back_to_back

  // Upstream port, 512-byte strap, slot power message captured
  task automatic test_upstream();
    do_reset(1'b1, 1'b1);
    rd_chk(8'hc0, {2'h0, 5'h00, 1'b0, 4'h5, 4'h2, 8'h00, 8'h10});
    rd_chk(8'hc4, 32'h00008002);
    spl_msg(8'ha5, 2'h3);
    rd_chk(8'hc4, {4'h0, 2'h3, 8'ha5, 2'h0, 1'b1, 12'h0, 3'h2});
    spl_msg(8'hff, 2'h1);
    rd_chk(8'hc4, {4'h0, 2'h1, 8'hff, 2'h0, 1'b1, 12'h0, 3'h2});
    $display("test_upstream done");
  endtask : test_upstream

  // ============================================================
  // Closing report
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    test_reset_values();
    test_pin_writes();
    test_read_only();
    test_sideband();
    test_back_to_back();
    test_upstream();
    print_verdict();
  end

endmodule : tb_switch_port_pcie_capability_regs

`default_nettype wire
